//--- src/pph_top.v
// Parallel port handshake block: APB registers, mode decode and pin control
// What this block does
// - Control bits 7,6 set make port A bidirectional
// - Bidirectional port A direction follows acknowledge input
// - Bidirectional, B not strobed: C0, C1 outputs only if bit3 zero
// - Bits 7,1 set, bit2 clear: B input
// - Bits 7 set, 2,1 clear: B latched output
// - Port C lines 3 to 7 general only when A mode 0
// - Bits 7,2,1 set, bit6 ignored: B strobed
// - Strobed B: C0 drives interrupt request
// - Strobed B: C1 drives input buffer full
// - Strobed B: C2 low strobe loads data
// - Port A mode 1 reserves C3 to C7
`timescale 1ns/1ps
`include "pph_defines.vh"

module pph_top (
   input wire ref_clk,
   input wire srst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PPH_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata_ff,
   output reg pready_ff,
   output reg pslverr_ff,
   // Port A pins
   input wire [7:0] pa_in,
   output reg [7:0] pa_out_ff,
   output reg [7:0] pa_oe_ff,
   // Port B pins
   input wire [7:0] pb_in,
   output reg [7:0] pb_out_ff,
   output reg [7:0] pb_oe_ff,
   // Port C pins, partly handshake lines
   input wire [7:0] pc_in,
   output reg [7:0] pc_out_ff,
   output reg [7:0] pc_oe_ff,
   // Interrupt
   output wire irq
);

   // ************************************************************
   // Address decode
   // ************************************************************
   wire [`PPH_ADDR_W-1:0] addr_port_a; // Byte address of port A data
   wire [`PPH_ADDR_W-1:0] addr_port_b; // Byte address of port B data
   wire [`PPH_ADDR_W-1:0] addr_port_c; // Byte address of port C data
   wire [`PPH_ADDR_W-1:0] addr_ctrl;   // Byte address of the control word
   wire [`PPH_ADDR_W-1:0] addr_status; // Byte address of the status
   wire [`PPH_ADDR_W-1:0] addr_mask;   // Byte address of the mask
   wire sel_a;      // Port A selected
   wire sel_b;      // Port B selected
   wire sel_c;      // Port C selected
   wire sel_ctrl;   // Control word selected
   wire sel_status; // Status selected
   wire sel_mask;   // Mask selected
   wire mapped;     // Any register selected

   assign addr_port_a = {2'b00, `PPH_IDX_PORT_A, 2'b00};
   assign addr_port_b = {2'b00, `PPH_IDX_PORT_B, 2'b00};
   assign addr_port_c = {2'b00, `PPH_IDX_PORT_C, 2'b00};
   assign addr_ctrl = {2'b00, `PPH_IDX_CTRL, 2'b00};
   assign addr_status = {2'b00, `PPH_IDX_STATUS, 2'b00};
   assign addr_mask = {2'b00, `PPH_IDX_MASK, 2'b00};

   assign sel_a = (paddr == addr_port_a);
   assign sel_b = (paddr == addr_port_b);
   assign sel_c = (paddr == addr_port_c);
   assign sel_ctrl = (paddr == addr_ctrl);
   assign sel_status = (paddr == addr_status);
   assign sel_mask = (paddr == addr_mask);
   assign mapped = sel_a | sel_b | sel_c | sel_ctrl | sel_status | sel_mask;

   // ************************************************************
   // APB handshake
   // ************************************************************
   wire acc_first; // First access cycle, read data is captured here
   wire acc_done;  // Completing edge of the transfer
   wire wr_go;     // Write takes effect
   wire wr_low;    // Write with the low byte lane enabled

   // One wait state so that read data comes from a flop
   assign acc_first = psel & penable & ~pready_ff;
   assign acc_done = psel & penable & pready_ff;
   assign wr_go = acc_done & pwrite & mapped;
   // Registers are eight bits wide and sit in byte lane zero
   assign wr_low = wr_go & pstrb[0];

   // ************************************************************
   // Control word and mode decode
   // ************************************************************
   reg [7:0] cw_ff;       // Current mode word
   wire a_bidir;          // Port A in mode 2
   wire a_mode1;          // Port A in mode 1
   wire a_mode0;          // Port A in basic mode
   wire b_strobed;        // Port B strobed input
   wire b_mode0_in;       // Port B basic input
   wire b_mode0_out;      // Port B basic latched output
   wire b_mode1_out;      // Port B mode 1 output, no handshake here
   wire cw_mode_wr;       // Mode set write
   wire cw_bit_wr;        // Single port C bit write

   // Bit 7 of the written byte picks mode set or port C bit write
   assign cw_mode_wr = wr_low & sel_ctrl & pwdata[`PPH_CW_MODE_SET];
   assign cw_bit_wr = wr_low & sel_ctrl & ~pwdata[`PPH_CW_MODE_SET];

   // Port A bidirectional whenever bit 6 is set, other bits ignored
   assign a_bidir = cw_ff[`PPH_CW_A_BIDIR];
   assign a_mode1 = ~cw_ff[`PPH_CW_A_BIDIR] & cw_ff[`PPH_CW_A_MODE1];
   assign a_mode0 = ~a_bidir & ~a_mode1;
   assign b_strobed = cw_ff[`PPH_CW_B_MODE1] & cw_ff[`PPH_CW_B_IN];
   assign b_mode0_in = ~cw_ff[`PPH_CW_B_MODE1] & cw_ff[`PPH_CW_B_IN];
   assign b_mode0_out = ~cw_ff[`PPH_CW_B_MODE1] & ~cw_ff[`PPH_CW_B_IN];
   assign b_mode1_out = cw_ff[`PPH_CW_B_MODE1] & ~cw_ff[`PPH_CW_B_IN];

   // Mode word; only writes with bit 7 set reach it
   always @(posedge ref_clk) begin
      if (srst) begin
         cw_ff <= `PPH_CW_RESET;
      end else if (cw_mode_wr) begin
         cw_ff <= pwdata[7:0];
      end
   end

   // ************************************************************
   // Output latches of the three ports
   // ************************************************************
   reg [7:0] pa_latch_ff; // Last byte written to port A
   reg [7:0] pb_latch_ff; // Last byte written to port B
   reg [7:0] pc_latch_ff; // Port C output and enable latch

   // Port A and B latches keep the last written byte
   always @(posedge ref_clk) begin
      if (srst) begin
         pa_latch_ff <= `PPH_BYTE_RESET;
         pb_latch_ff <= `PPH_BYTE_RESET;
      end else begin
         if (wr_low & sel_a) begin
            pa_latch_ff <= pwdata[7:0];
         end
         if (wr_low & sel_b) begin
            pb_latch_ff <= pwdata[7:0];
         end
      end
   end

   // Port C latch: whole byte write or single bit set and reset
   always @(posedge ref_clk) begin
      if (srst) begin
         pc_latch_ff <= `PPH_BYTE_RESET;
      end else if (wr_low & sel_c) begin
         pc_latch_ff <= pwdata[7:0];
      end else if (cw_bit_wr) begin
         // Bits 3..1 pick the line, bit 0 is its value
         pc_latch_ff[pwdata[3:1]] <= pwdata[0];
      end
   end

   // ************************************************************
   // Strobed input of port B
   // ************************************************************
   wire [7:0] pb_strobed_data; // Byte latched by the strobe
   wire pb_full;               // Input buffer full
   wire ev_loaded;             // Byte latched pulse
   wire ev_overrun;            // Byte overwritten pulse
   wire pb_read;               // Processor reads port B

   // Clear at the capture edge so a strobe in the same edge is kept
   assign pb_read = acc_first & ~pwrite & sel_b & b_strobed;

   // Strobe input is port C line 2 while port B is strobed
   pph_strobe_latch u_strobe (
      .ref_clk(ref_clk),
      .srst(srst),
      .enable(b_strobed),
      .load_strobe_n(pc_in[`PPH_PC_LOAD]),
      .pin_data(pb_in),
      .read_clr(pb_read),
      .data_ff(pb_strobed_data),
      .full_ff(pb_full),
      .loaded_ff(ev_loaded),
      .overrun_ff(ev_overrun)
   );

   // ************************************************************
   // Interrupt status
   // ************************************************************
   reg ack_prev_ff;                // Acknowledge level last cycle
   wire ev_ack;                    // Falling acknowledge in mode 2
   wire [`PPH_EV_W-1:0] events;    // Event pulses
   wire [`PPH_EV_W-1:0] status;    // Sticky status
   wire [`PPH_EV_W-1:0] mask;      // Interrupt mask
   wire port_b_interrupt_request;  // Port B request, enabled by its latch bit

   assign ev_ack = a_bidir & ack_prev_ff & ~pc_in[`PPH_PC_ACK];
   assign events = {ev_ack, ev_overrun, ev_loaded};
   // Request while full and the port B enable bit is set
   assign port_b_interrupt_request = pb_full & pc_latch_ff[`PPH_PC_INTE_B];

   // Previous acknowledge level; idles high
   always @(posedge ref_clk) begin
      if (srst) begin
         ack_prev_ff <= 1'b1;
      end else begin
         ack_prev_ff <= pc_in[`PPH_PC_ACK];
      end
   end

   pph_irq_ctrl u_irq (
      .ref_clk(ref_clk),
      .srst(srst),
      .events(events),
      .status_wr(wr_low & sel_status),
      .mask_wr(wr_low & sel_mask),
      .wdata(pwdata[`PPH_EV_W-1:0]),
      .status_ff(status),
      .mask_ff(mask),
      .irq_ff(irq)
   );

   // ************************************************************
   // Port A and B pin drive
   // ************************************************************
   // Pin drive is one cycle behind its cause, from flops
   always @(posedge ref_clk) begin
      if (srst) begin
         pa_out_ff <= `PPH_BYTE_RESET;
         pa_oe_ff <= `PPH_BYTE_RESET;
         pb_out_ff <= `PPH_BYTE_RESET;
         pb_oe_ff <= `PPH_BYTE_RESET;
      end else begin
         pa_out_ff <= pa_latch_ff;
         pb_out_ff <= pb_latch_ff;
         if (a_bidir) begin
            // Drive out only while acknowledge is low
            pa_oe_ff <= {8{~pc_in[`PPH_PC_ACK]}};
         end else begin
            pa_oe_ff <= {8{~cw_ff[`PPH_CW_A_IN]}};
         end
         // Basic or mode 1 output drives; inputs never drive
         pb_oe_ff <= {8{b_mode0_out | b_mode1_out}};
      end
   end

   // ************************************************************
   // Port C line control, one slice per line
   // ************************************************************
   wire [7:0] nxt_pc_out; // Next drive value per line
   wire [7:0] nxt_pc_oe;  // Next enable per line

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pc
         if (gi == `PPH_PC_IRQ) begin : g_irq
            // Line 0: request in strobed mode, else general
            assign nxt_pc_out[gi] = b_strobed ? port_b_interrupt_request : pc_latch_ff[gi];
            // Under mode 2 with port B not strobed the line drives only while bit 3 is zero
            assign nxt_pc_oe[gi] = b_strobed |
               (a_bidir ? ~cw_ff[`PPH_CW_C_HI_IN] : ~cw_ff[`PPH_CW_C_LO_IN]);
         end else if (gi == `PPH_PC_FULL) begin : g_full
            // Line 1: buffer full in strobed mode, else general
            assign nxt_pc_out[gi] = b_strobed ? pb_full : pc_latch_ff[gi];
            assign nxt_pc_oe[gi] = b_strobed |
               (a_bidir ? ~cw_ff[`PPH_CW_C_HI_IN] : ~cw_ff[`PPH_CW_C_LO_IN]);
         end else if (gi == `PPH_PC_LOAD) begin : g_load
            // Line 2: strobe input in strobed mode, never driven then
            assign nxt_pc_out[gi] = pc_latch_ff[gi];
            assign nxt_pc_oe[gi] = ~b_strobed & ~cw_ff[`PPH_CW_C_LO_IN];
         end else begin : g_hi
            // Lines 3..7: general only while port A is in basic mode
            assign nxt_pc_out[gi] = pc_latch_ff[gi];
            assign nxt_pc_oe[gi] = a_mode0 & ~cw_ff[`PPH_CW_C_HI_IN];
         end

         // Registered line drive
         always @(posedge ref_clk) begin
            if (srst) begin
               pc_out_ff[gi] <= 1'b0;
               pc_oe_ff[gi] <= 1'b0;
            end else begin
               pc_out_ff[gi] <= nxt_pc_out[gi];
               pc_oe_ff[gi] <= nxt_pc_oe[gi];
            end
         end
      end
   endgenerate

   // ************************************************************
   // Read data path
   // ************************************************************
   reg [7:0] rd_byte; // Selected register byte
   wire [7:0] pc_view; // Port C as seen by software

   // Driven lines read back the drive, others read the pins
   assign pc_view = (pc_oe_ff & pc_out_ff) | (~pc_oe_ff & pc_in);

   // Read multiplexer; the control word is write only and reads zero
   always @* begin
      rd_byte = 8'h00;
      if (sel_a) begin
         rd_byte = (a_bidir | cw_ff[`PPH_CW_A_IN]) ? pa_in : pa_latch_ff;
      end else if (sel_b) begin
         if (b_strobed) begin
            rd_byte = pb_strobed_data;
         end else if (b_mode0_in) begin
            rd_byte = pb_in;
         end else begin
            rd_byte = pb_latch_ff;
         end
      end else if (sel_c) begin
         rd_byte = pc_view;
      end else if (sel_status) begin
         rd_byte = {5'h00, status};
      end else if (sel_mask) begin
         rd_byte = {5'h00, mask};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Ready rises one cycle into the access phase, data and error with it
   always @(posedge ref_clk) begin
      if (srst) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else if (acc_first) begin
         pready_ff <= 1'b1;
         prdata_ff <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
         // Unmapped addresses answer with an error and no effect
         pslverr_ff <= ~mapped;
      end else begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end
   end

endmodule // pph_top

//--- src/pph_defines.vh
// Constants for the parallel port handshake configuration block
`ifndef PPH_DEFINES_VH
`define PPH_DEFINES_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define PPH_IDX_PORT_A 8'hE4
`define PPH_IDX_PORT_B 8'hE5
`define PPH_IDX_PORT_C 8'hE6
`define PPH_IDX_CTRL 8'hE7
`define PPH_IDX_STATUS 8'hF0
`define PPH_IDX_MASK 8'hF1
`define PPH_ADDR_W 12

// ************************************************************
// Control word field positions
// ************************************************************
`define PPH_CW_MODE_SET 7
`define PPH_CW_A_BIDIR 6
`define PPH_CW_A_MODE1 5
`define PPH_CW_A_IN 4
`define PPH_CW_C_HI_IN 3
`define PPH_CW_B_MODE1 2
`define PPH_CW_B_IN 1
`define PPH_CW_C_LO_IN 0

// ************************************************************
// Port C handshake bit positions
// ************************************************************
`define PPH_PC_IRQ 0
`define PPH_PC_FULL 1
`define PPH_PC_LOAD 2
`define PPH_PC_INTE_B 2
`define PPH_PC_ACK 6

// ************************************************************
// Reset values
// ************************************************************
`define PPH_CW_RESET 8'h9B
`define PPH_BYTE_RESET 8'h00
`define PPH_EV_RESET 3'h0

// ************************************************************
// Interrupt event bit positions
// ************************************************************
`define PPH_EV_W 3
`define PPH_EV_LOADED 0
`define PPH_EV_OVERRUN 1
`define PPH_EV_ACK 2

`endif

//--- src/pph_strobe_latch.v
// Strobed input latch of port B with buffer full tracking
`timescale 1ns/1ps
`include "pph_defines.vh"

module pph_strobe_latch (
   input wire ref_clk,
   input wire srst,
   input wire enable,          // Port B is in strobed input mode
   input wire load_strobe_n,   // Strobe from the peripheral, active low
   input wire [7:0] pin_data,  // Port B pins
   input wire read_clr,        // Processor reads port B
   output reg [7:0] data_ff,   // Latched byte
   output reg full_ff,         // Input buffer full
   output reg loaded_ff,       // One-cycle pulse: a byte was latched
   output reg overrun_ff       // One-cycle pulse: latched while still full
);

   // ************************************************************
   // Strobe edge detection
   // ************************************************************
   reg ld_prev_ff; // Strobe seen last cycle
   wire ld_fall;   // Falling strobe edge

   // Pins are synchronous to ref_clk, so no synchroniser is needed
   assign ld_fall = enable & ld_prev_ff & ~load_strobe_n;

   // Previous strobe level; idles high
   always @(posedge ref_clk) begin
      if (srst) begin
         ld_prev_ff <= 1'b1;
      end else begin
         ld_prev_ff <= load_strobe_n;
      end
   end

   // ************************************************************
   // Data latch and buffer full flag
   // ************************************************************
   // Latch on the strobe's falling edge; a new byte beats a read clear
   always @(posedge ref_clk) begin
      if (srst) begin
         data_ff <= `PPH_BYTE_RESET;
         full_ff <= 1'b0;
         loaded_ff <= 1'b0;
         overrun_ff <= 1'b0;
      end else begin
         loaded_ff <= ld_fall;
         overrun_ff <= ld_fall & full_ff;
         if (ld_fall) begin
            // Set wins over the read clear in the same cycle
            data_ff <= pin_data;
            full_ff <= 1'b1;
         end else if (read_clr | ~enable) begin
            // Leaving the mode drops a stale full flag
            full_ff <= 1'b0;
         end
      end
   end

endmodule // pph_strobe_latch

//--- src/pph_irq_ctrl.v
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`include "pph_defines.vh"

module pph_irq_ctrl (
   input wire ref_clk,
   input wire srst,
   input wire [`PPH_EV_W-1:0] events,   // One-cycle event pulses
   input wire status_wr,                // Write one to clear strobe
   input wire mask_wr,                  // Mask write strobe
   input wire [`PPH_EV_W-1:0] wdata,    // Write data
   output reg [`PPH_EV_W-1:0] status_ff,
   output reg [`PPH_EV_W-1:0] mask_ff,
   output reg irq_ff                    // Level interrupt, active high
);

   // ************************************************************
   // Status, mask and interrupt level
   // ************************************************************
   wire [`PPH_EV_W-1:0] nxt_status; // Next sticky status

   // A new event always survives a clear in the same cycle
   assign nxt_status = (status_ff & ~({`PPH_EV_W{status_wr}} & wdata)) | events;

   // Status, mask and registered interrupt level
   always @(posedge ref_clk) begin
      if (srst) begin
         status_ff <= `PPH_EV_RESET;
         mask_ff <= `PPH_EV_RESET;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         if (mask_wr) begin
            mask_ff <= wdata;
         end
         // One cycle behind status so the output comes from a flop
         irq_ff <= |(status_ff & mask_ff);
      end
   end

endmodule // pph_irq_ctrl

//--- tb/pph_chk_asserts.sv
// Assertion checker for the parallel port handshake block
`timescale 1ns/1ps
`include "pph_defines.vh"

module pph_chk (
   input wire ref_clk,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PPH_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata_ff,
   input wire pready_ff,
   input wire pslverr_ff,
   input wire [7:0] pa_oe_ff,
   input wire [7:0] pb_oe_ff,
   input wire [7:0] pc_in,
   input wire [7:0] pc_out_ff,
   input wire [7:0] pc_oe_ff
);
   // ****
   // Mode word shadow
   // ****
   localparam [11:0] CW_A = {2'h0, `PPH_IDX_CTRL, 2'h0};
   localparam [11:0] PB_A = {2'h0, `PPH_IDX_PORT_B, 2'h0};
   reg [7:0] cw_ff; // Last mode word
   reg [7:0] cwd_ff; // Delayed, since the pins are registered
   wire smode = ~cwd_ff[6] & (cwd_ff[2:1] == 2'h3); // Port B strobed, port A not in mode 2
   // Bit write words leave the mode alone, so only bit 7 words count
   always @(posedge ref_clk) begin
      if (srst) begin
         cw_ff <= `PPH_CW_RESET;
         cwd_ff <= `PPH_CW_RESET;
      end else begin
         if (psel & penable & pready_ff & pwrite & pstrb[0] & paddr == CW_A & pwdata[7]) begin
            cw_ff <= pwdata[7:0];
         end
         cwd_ff <= cw_ff;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   chk_b_input: assert property (cwd_ff[2:1] == 2'h1 |-> pb_oe_ff == 8'h00)
      else $error("port B driven in input mode");
   chk_b_latched: assert property (cwd_ff[2:1] == 2'h0 |-> pb_oe_ff == 8'hFF)
      else $error("port B not driven in output mode");
   chk_bidir_upper: assert property (cwd_ff[6] |-> pc_oe_ff[7:3] == 5'h00)
      else $error("upper port C driven in bidir mode");
   chk_mode1_upper: assert property (cwd_ff[6:5] == 2'h1 |-> pc_oe_ff[7:3] == 5'h00)
      else $error("upper port C driven in mode 1");
   chk_bidir_low: assert property (cwd_ff[6] && cwd_ff[2:1] != 2'h3 |-> pc_oe_ff[1:0] == {2{~cwd_ff[3]}})
      else $error("low port C direction wrong in bidir");
   chk_bidir_dir: assert property (cwd_ff[6] && $past(cwd_ff[6]) |-> pa_oe_ff == {8{~$past(pc_in[6])}})
      else $error("port A direction not following acknowledge");
   chk_strobe_lines: assert property (smode |-> pc_oe_ff[2:0] == 3'h3)
      else $error("handshake line directions wrong");
   chk_strobe_full: assert property (smode && $fell(pc_in[2]) |-> ##2 pc_out_ff[1])
      else $error("buffer full not raised by strobe");
   chk_read_clear: assert property (smode && psel && penable && !pwrite && paddr == PB_A && !pready_ff && pc_in[2]
      |-> ##2 !pc_out_ff[1])
      else $error("buffer full not cleared by read");
   chk_apb_wait: assert property (psel && !penable |-> ##2 pready_ff)
      else $error("bus answer late");
   chk_err_data: assert property (pslverr_ff |-> pready_ff && prdata_ff == 32'h0)
      else $error("error without ready or with data");
   cover property (smode && $fell(pc_in[2]));
   cover property (cwd_ff[6] && !pc_in[6]);
   cover property (pslverr_ff);
endmodule // pph_chk

bind pph_top pph_chk u_chk (
   .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
   .pslverr_ff(pslverr_ff), .pa_oe_ff(pa_oe_ff), .pb_oe_ff(pb_oe_ff), .pc_in(pc_in),
   .pc_out_ff(pc_out_ff), .pc_oe_ff(pc_oe_ff)
);

//--- tb/pph_periph.sv
// Peripheral model: strobes bytes into port B and drives acknowledge
`timescale 1ns/1ps

module pph_periph (
   input wire ref_clk,
   output reg load_strobe_n,
   output reg ack_n,
   output reg [7:0] pb_drv
);
   // Idle: strobe and acknowledge high
   initial begin
      load_strobe_n = 1'h1;
      ack_n = 1'h1;
      pb_drv = 8'h5A;
   end
   // Byte, then a strobe held low for lo cycles; data is let go after it
   task send(input [7:0] b, input integer lo);
      begin
         @(posedge ref_clk);
         pb_drv <= b;
         @(posedge ref_clk);
         load_strobe_n <= 1'h0;
         repeat (lo) @(posedge ref_clk);
         load_strobe_n <= 1'h1;
         @(posedge ref_clk);
         pb_drv <= ~b; // Released bus shows no stale byte
      end
   endtask
   // Acknowledge level; low turns port A outward
   task set_ack(input v);
      begin
         @(posedge ref_clk);
         ack_n <= v;
      end
   endtask
endmodule // pph_periph

//--- tb/tb.sv
// Self-checking testbench for the parallel port handshake block
`timescale 1ns/1ps
`include "pph_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tb;
   // ****
   // Signals and instances
   // ****
   localparam [11:0] A_PA = {2'h0, `PPH_IDX_PORT_A, 2'h0};
   localparam [11:0] A_PB = {2'h0, `PPH_IDX_PORT_B, 2'h0};
   localparam [11:0] A_CW = {2'h0, `PPH_IDX_CTRL, 2'h0};
   localparam [11:0] A_ST = {2'h0, `PPH_IDX_STATUS, 2'h0};
   localparam [11:0] A_MK = {2'h0, `PPH_IDX_MASK, 2'h0};
   reg ref_clk = 1'h0;
   reg srst = 1'h1;
   reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [3:0] pstrb = 4'hF;
   reg [7:0] pa_in = 8'h00;
   wire [31:0] prdata_ff;
   wire pready_ff, pslverr_ff, irq, strobe_n, ack_n;
   wire [7:0] pa_out_ff, pa_oe_ff, pb_in, pb_out_ff, pb_oe_ff, pc_out_ff, pc_oe_ff;
   wire [7:0] pc_in = {1'h0, ack_n, 3'h0, strobe_n, 2'h0}; // Handshake inputs from the peripheral
   integer err_total = 0;
   integer num_checks = 0;
   reg [31:0] rd; // Last read data
   reg er; // Last error flag
   pph_top i_dut (
      .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
      .pa_in(pa_in), .pa_out_ff(pa_out_ff), .pa_oe_ff(pa_oe_ff), .pb_in(pb_in), .pb_out_ff(pb_out_ff),
      .pb_oe_ff(pb_oe_ff), .pc_in(pc_in), .pc_out_ff(pc_out_ff), .pc_oe_ff(pc_oe_ff), .irq(irq));
   pph_periph i_per (.ref_clk(ref_clk), .load_strobe_n(strobe_n), .ack_n(ack_n), .pb_drv(pb_in));
   initial forever #10 ref_clk = ~ref_clk;
   // ****
   // Tasks
   // ****
   // One bus transfer; an idle edge first so no signal is set twice at once
   task apb(input w, input [11:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge ref_clk);
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h0, d};
         @(posedge ref_clk);
         penable <= 1'h1;
         n = 0;
         while (pready_ff !== 1'h1 && n < 20) begin
            @(posedge ref_clk);
            n++;
         end
         `CHK("pready", 1'h1, pready_ff)
         rd = prdata_ff;
         er = pslverr_ff;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task t_reset;
      begin
         apb(1'h0, A_CW, 8'h00);
         `CHK("cw_read", 32'h0, rd)
         `CHK("oe_reset", 24'h0, {pa_oe_ff, pb_oe_ff, pc_oe_ff})
         apb(1'h0, 12'hFFC, 8'h00);
         `CHK("unmapped", 1'h1, er)
      end
   endtask
   task t_latched;
      begin
         apb(1'h1, A_CW, 8'h80);
         apb(1'h1, A_PB, 8'hA5);
         apb(1'h1, A_PA, 8'h96);
         pstrb <= 4'hE;
         apb(1'h1, A_PB, 8'h3C);
         pstrb <= 4'hF;
         apb(1'h1, A_CW, 8'h05);
         cyc(2);
         `CHK("pb_out", 8'hA5, pb_out_ff)
         `CHK("pa_out", 8'h96, pa_out_ff)
         `CHK("pb_oe", 8'hFF, pb_oe_ff)
         `CHK("pc_oe", 8'hFF, pc_oe_ff)
         `CHK("pc_bit2", 1'h1, pc_out_ff[2])
      end
   endtask
   task t_input;
      begin
         apb(1'h1, A_CW, 8'h82);
         apb(1'h0, A_PB, 8'h00);
         `CHK("pb_read", 32'h5A, rd)
         `CHK("pb_oe_in", 8'h00, pb_oe_ff)
      end
   endtask
   task t_bidir;
      begin
         apb(1'h1, A_CW, 8'hC0); // Port C data lines left alone here
         i_per.set_ack(1'h0);
         cyc(2);
         `CHK("pa_oe_ack0", 8'hFF, pa_oe_ff)
         `CHK("pc_oe_low", 2'h3, pc_oe_ff[1:0])
         `CHK("pc_oe_up", 5'h00, pc_oe_ff[7:3])
         i_per.set_ack(1'h1);
         pa_in <= 8'h69;
         cyc(2);
         `CHK("pa_oe_ack1", 8'h00, pa_oe_ff)
         apb(1'h0, A_PA, 8'h00);
         `CHK("pa_read", 32'h69, rd)
         apb(1'h1, A_CW, 8'hC8);
         cyc(2);
         `CHK("pc_oe_b3", 2'h0, pc_oe_ff[1:0])
         apb(1'h1, A_CW, 8'hA4);
         cyc(2);
         `CHK("pc_oe_m1", 5'h00, pc_oe_ff[7:3])
         `CHK("pb_oe_m1", 8'hFF, pb_oe_ff)
      end
   endtask
   task t_strobe;
      begin
         apb(1'h1, A_CW, 8'h86);
         apb(1'h1, A_CW, 8'h05);
         apb(1'h1, A_MK, 8'h01);
         i_per.send(8'hC3, 1);
         cyc(3);
         `CHK("hs_lines", 5'h0F, {pc_oe_ff[2:0], pc_out_ff[1:0]})
         `CHK("irq_on", 1'h1, irq)
         apb(1'h0, A_PB, 8'h00);
         `CHK("pb_data", 32'hC3, rd)
         cyc(2);
         `CHK("full_clr", 2'h0, pc_out_ff[1:0])
         apb(1'h1, A_ST, 8'h01);
         apb(1'h1, A_MK, 8'h00);
         i_per.send(8'h11, 3); // Slow peripheral
         i_per.send(8'h22, 1);
         apb(1'h1, A_CW, 8'h04);
         cyc(2);
         `CHK("port_b_interrupt_request_off", 2'h2, pc_out_ff[1:0])
         `CHK("irq_masked", 1'h0, irq)
         apb(1'h0, A_ST, 8'h00);
         `CHK("status", 32'h7, rd)
         apb(1'h1, A_MK, 8'h07);
         apb(1'h1, A_ST, 8'h07);
         cyc(2);
         `CHK("irq_clr", 1'h0, irq)
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // ****
   // Sequence and watchdog
   // ****
   initial begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'h0;
      t_reset;
      t_latched;
      t_input;
      t_bidir;
      t_strobe;
      print_verdict;
   end
   // Tests need some 130 cycles; 2000 means a hang
   initial begin
      #40000;
      err_total++;
      print_verdict;
   end
endmodule // tb
